// >>> core/accel_status_interrupt_flags.sv
// module: operating status, sticky interrupt flags and mode tracking of the accelerometer
`timescale 1ns/100ps
module accel_status_interrupt_flags
   import accel_status_pkg::*;
#(
   parameter int DEPTH = QUEUE_DEPTH
) (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_RD,
   input wire logic REG_WR,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic IS_SPI,
   input wire logic WRITE_CLEAR_SEL,
   input wire logic REARM_ON_CLEAR,
   input wire logic [7:0] IRQ_ENABLE,
   input wire logic [4:0] QUEUE_WATERMARK_LEVEL,
   input wire logic [5:0] FIFO_COUNT,
   input wire logic [2:0] MODE_CMD,
   input wire logic MODE_CMD_WR,
   input wire logic [7:0] BURST_SAMPLE_COUNT,
   input wire logic HEARTBEAT_TICK,
   input wire logic SAMPLE_TICK,
   input wire logic SAMPLE_WRITTEN,
   input wire logic SAMPLE_READ,
   input wire logic ACTIVITY_EVENT,
   output logic SAMPLING_ENABLE,
   output logic DETECTOR_ENABLE,
   output logic QUEUE_ENABLE,
   output logic DETECTOR_RESET,
   output logic ANY_IRQ_PENDING,
   output logic [7:0] IRQ_FLAGS
);

   // ****************************************************************
   // state
   // ****************************************************************
   mode_type mode_reg;
   mode_type mode_next;
   logic [7:0] burst_left_reg;
   logic [7:0] burst_left_next;
   logic new_data_reg;
   logic [7:0] flags_reg;
   logic [7:0] flags_next;
   logic empty_armed_reg;
   logic full_armed_reg;
   logic detector_halt_reg;
   logic [7:0] rdata_reg;
   logic rvalid_reg;
   logic [2:0] reported_mode;

   // ****************************************************************
   // mode command decode
   // ****************************************************************
   logic cmd_valid;
   mode_type cmd_mode;

   // reserved command codes are ignored, the device keeps its mode
   always_comb begin
      cmd_valid = 1'b1;
      case (MODE_CMD)
         MODE_CODE_SLEEP: cmd_mode = M_SLEEP;
         MODE_CODE_STANDBY: cmd_mode = M_STANDBY;
         MODE_CODE_ACTIVITY_WATCH: cmd_mode = M_ACTIVITY_WATCH;
         MODE_CODE_CONTINUOUS_WAKE: cmd_mode = M_CONTINUOUS_WAKE;
         MODE_CODE_COMBINED_WAKE: cmd_mode = M_COMBINED_WAKE;
         MODE_CODE_TRIGGERED_BURST: cmd_mode = M_TRIGGERED_BURST;
         default: begin
            cmd_mode = M_SLEEP;
            cmd_valid = 1'b0;
         end
      endcase
   end

   // live mode to status code
   logic [2:0] live_code;

   always_comb begin
      case (mode_reg)
         M_SLEEP: live_code = MODE_CODE_SLEEP;
         M_STANDBY: live_code = MODE_CODE_STANDBY;
         M_ACTIVITY_WATCH: live_code = MODE_CODE_ACTIVITY_WATCH;
         M_CONTINUOUS_WAKE: live_code = MODE_CODE_CONTINUOUS_WAKE;
         M_COMBINED_WAKE: live_code = MODE_CODE_COMBINED_WAKE;
         M_TRIGGERED_BURST: live_code = MODE_CODE_TRIGGERED_BURST;
         default: live_code = MODE_CODE_SLEEP;
      endcase
   end

   // ****************************************************************
   // per-mode activity
   // ****************************************************************
   wire in_watch = (mode_reg == M_ACTIVITY_WATCH);
   wire in_continuous = (mode_reg == M_CONTINUOUS_WAKE);
   wire in_combined = (mode_reg == M_COMBINED_WAKE);
   wire in_burst = (mode_reg == M_TRIGGERED_BURST);

   // watch runs the detector only; continuous keeps it off; combined runs sampling, queue and, unless halted, the detector
   assign SAMPLING_ENABLE = in_continuous | in_combined | in_burst;
   assign QUEUE_ENABLE = in_continuous | in_combined | in_burst;
   assign DETECTOR_ENABLE = in_watch | (in_combined & ~detector_halt_reg);

   // qualified events; the detector's own events count only while it runs
   wire activity_seen = ACTIVITY_EVENT & DETECTOR_ENABLE;
   wire watch_to_continuous = in_watch & activity_seen;
   wire combined_activity = in_combined & activity_seen;
   wire sample_in_acq_mode = SAMPLE_TICK & (in_continuous | in_burst);
   wire burst_counted = in_burst & SAMPLE_TICK & (burst_left_reg != BURST_CONTINUOUS);
   wire burst_done = burst_counted & (burst_left_reg == 8'h01);

   // ****************************************************************
   // mode sequencing
   // ****************************************************************
   // a host command beats an automatic move arriving in the same cycle
   always_comb begin
      mode_next = mode_reg;
      burst_left_next = burst_left_reg;
      if (MODE_CMD_WR && cmd_valid) begin
         mode_next = cmd_mode;
         burst_left_next = BURST_SAMPLE_COUNT; // zero means run until commanded otherwise
      end else begin
         case (mode_reg)
            M_ACTIVITY_WATCH: begin
               if (watch_to_continuous) begin
                  mode_next = M_CONTINUOUS_WAKE;
               end
            end
            M_TRIGGERED_BURST: begin
               if (burst_counted) begin
                  burst_left_next = burst_left_reg - 8'h01;
               end
               if (burst_done) begin
                  mode_next = M_SLEEP;
               end
            end
            default: begin
               mode_next = mode_reg;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         mode_reg <= M_SLEEP;
         burst_left_reg <= BURST_COUNT_RESET;
      end else begin
         mode_reg <= mode_next;
         burst_left_reg <= burst_left_next;
      end
   end

   // status field trails the live mode by the heartbeat pipeline
   mode_report_delay #(
      .STAGES(MODE_REPORT_STAGES),
      .WIDTH(3)
   ) u_mode_report (
      .clk(CLK),
      .srst(SRST),
      .heartbeat_tick(HEARTBEAT_TICK),
      .live_code(live_code),
      .reported_code(reported_mode)
   );

   // ****************************************************************
   // queue level conditions
   // ****************************************************************
   // counts above DEPTH are not expected from the queue; they still read as full
   wire queue_empty = (FIFO_COUNT == 6'h00);
   wire queue_full = (FIFO_COUNT >= 6'(DEPTH));
   wire queue_watermark = (FIFO_COUNT >= {1'b0, QUEUE_WATERMARK_LEVEL});

   // ****************************************************************
   // register access decode
   // ****************************************************************
   wire hit_status = (REG_ADDR == OPERATING_STATUS_ADDR);
   wire hit_flags = (REG_ADDR == INTERRUPT_FLAGS_ADDR);
   wire clear_by_write = IS_SPI | WRITE_CLEAR_SEL;

   // spi always clears by write; i2c by read unless the write option is picked
   wire clear_access = hit_flags & (clear_by_write ? REG_WR : REG_RD);

   // only what is pending now is cleared; later arrivals survive
   wire [7:0] clear_mask = clear_access ? flags_reg : 8'h00;

   // ****************************************************************
   // flag set conditions
   // ****************************************************************
   logic [7:0] set_raw;
   logic [7:0] set_vec;

   always_comb begin
      set_raw = 8'h00;
      set_raw[WAKE_IRQ_BIT] = watch_to_continuous;
      set_raw[SAMPLE_ACQUIRED_IRQ_BIT] = sample_in_acq_mode;
      set_raw[QUEUE_EMPTY_IRQ_BIT] = queue_empty & empty_armed_reg;
      set_raw[QUEUE_FULL_IRQ_BIT] = queue_full & full_armed_reg;
      set_raw[QUEUE_WATERMARK_IRQ_BIT] = queue_watermark;
      set_raw[COMBINED_ACTIVITY_IRQ_BIT] = combined_activity;
   end

   // per-flag enable gate, reserved bits never set
   genvar b;
   generate
      for (b = 0; b < 8; b++) begin : g_gate
         assign set_vec[b] = set_raw[b] & IRQ_ENABLE[b] & FLAG_IMPLEMENTED_MASK[b];
      end
   endgenerate

   // set wins over a clear landing in the same cycle
   assign flags_next = (flags_reg & ~clear_mask) | set_vec;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         flags_reg <= INTERRUPT_FLAGS_RESET;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // ****************************************************************
   // edge arming for the empty and full flags
   // ****************************************************************
   // armed from reset so the first empty counts; re-armed only by leaving the condition
   always_ff @(posedge CLK) begin
      if (SRST) begin
         empty_armed_reg <= 1'b1;
         full_armed_reg <= 1'b1;
      end else begin
         if (!queue_empty) begin
            empty_armed_reg <= 1'b1;
         end else if (set_vec[QUEUE_EMPTY_IRQ_BIT]) begin
            empty_armed_reg <= 1'b0;
         end
         if (!queue_full) begin
            full_armed_reg <= 1'b1;
         end else if (set_vec[QUEUE_FULL_IRQ_BIT]) begin
            full_armed_reg <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // activity detector halt and rearm
   // ****************************************************************
   wire combined_flag_cleared = clear_mask[COMBINED_ACTIVITY_IRQ_BIT];
   wire rearm_now = REARM_ON_CLEAR & combined_flag_cleared;
   wire halt_on_event = combined_activity;

   // an event the running detector sees in the clearing cycle halts it despite the rearm
   always_ff @(posedge CLK) begin
      if (SRST) begin
         detector_halt_reg <= 1'b0;
      end else if (halt_on_event) begin
         detector_halt_reg <= 1'b1;
      end else if (!in_combined) begin
         detector_halt_reg <= 1'b0;
      end else if (rearm_now) begin
         detector_halt_reg <= 1'b0;
      end
   end

   // detector reset strobe in the same cycle as the flag clear
   assign DETECTOR_RESET = rearm_now;

   // ****************************************************************
   // new sample indication
   // ****************************************************************
   // independent of any enable; a new sample beats a read in the same cycle
   always_ff @(posedge CLK) begin
      if (SRST) begin
         new_data_reg <= 1'b0;
      end else if (SAMPLE_WRITTEN) begin
         new_data_reg <= 1'b1;
      end else if (SAMPLE_READ) begin
         new_data_reg <= 1'b0;
      end
   end

   // ****************************************************************
   // read data
   // ****************************************************************
   logic [7:0] status_word;

   always_comb begin
      status_word = OPERATING_STATUS_RESET;
      status_word[MODE_MSB:MODE_LSB] = reported_mode;
      status_word[NEW_DATA_BIT] = new_data_reg;
      status_word[QUEUE_EMPTY_BIT] = queue_empty;
      status_word[QUEUE_FULL_BIT] = queue_full;
      status_word[QUEUE_WATERMARK_BIT] = queue_watermark;
      status_word[ANY_IRQ_PENDING_BIT] = |flags_reg;
   end

   // unmapped addresses read zero; flag read returns the pre-clear snapshot
   wire [7:0] read_mux = hit_status ? status_word : (hit_flags ? flags_reg : 8'h00);

   always_ff @(posedge CLK) begin
      if (SRST) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= REG_RD;
         if (REG_RD) begin
            rdata_reg <= read_mux;
         end
      end
   end

   assign REG_RDATA = rdata_reg;
   assign REG_RVALID = rvalid_reg;
   assign ANY_IRQ_PENDING = |flags_reg;
   assign IRQ_FLAGS = flags_reg;

endmodule

// >>> core/accel_status_pkg.sv
// package: offsets, bit positions, mode codes and reset values of the status and flag logic
package accel_status_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] OPERATING_STATUS_ADDR = 8'h08;
   localparam logic [7:0] INTERRUPT_FLAGS_ADDR = 8'h09;
   localparam logic [7:0] OPERATING_STATUS_RESET = 8'h00;
   localparam logic [7:0] INTERRUPT_FLAGS_RESET = 8'h00;

   // ****************************************************************
   // operating status fields
   // ****************************************************************
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 2;
   localparam int NEW_DATA_BIT = 3;
   localparam int QUEUE_EMPTY_BIT = 4;
   localparam int QUEUE_FULL_BIT = 5;
   localparam int QUEUE_WATERMARK_BIT = 6;
   localparam int ANY_IRQ_PENDING_BIT = 7;

   // ****************************************************************
   // interrupt flag fields (bits 1:0 reserved, read zero)
   // ****************************************************************
   localparam int WAKE_IRQ_BIT = 2;
   localparam int SAMPLE_ACQUIRED_IRQ_BIT = 3;
   localparam int QUEUE_EMPTY_IRQ_BIT = 4;
   localparam int QUEUE_FULL_IRQ_BIT = 5;
   localparam int QUEUE_WATERMARK_IRQ_BIT = 6;
   localparam int COMBINED_ACTIVITY_IRQ_BIT = 7;
   localparam int FIRST_FLAG_BIT = 2;
   localparam logic [7:0] FLAG_IMPLEMENTED_MASK = 8'hFC;

   // ****************************************************************
   // mode codes as reported in the status field
   // ****************************************************************
   localparam logic [2:0] MODE_CODE_SLEEP = 3'h0;
   localparam logic [2:0] MODE_CODE_STANDBY = 3'h1;
   localparam logic [2:0] MODE_CODE_ACTIVITY_WATCH = 3'h2;
   localparam logic [2:0] MODE_CODE_CONTINUOUS_WAKE = 3'h5;
   localparam logic [2:0] MODE_CODE_COMBINED_WAKE = 3'h6;
   localparam logic [2:0] MODE_CODE_TRIGGERED_BURST = 3'h7;
   localparam logic [2:0] MODE_CODE_RESET = 3'h0;

   typedef enum logic [2:0] {
      M_SLEEP,
      M_STANDBY,
      M_ACTIVITY_WATCH,
      M_CONTINUOUS_WAKE,
      M_COMBINED_WAKE,
      M_TRIGGERED_BURST
   } mode_type;

   // ****************************************************************
   // counts
   // ****************************************************************
   localparam int QUEUE_DEPTH = 32;
   localparam int MODE_REPORT_STAGES = 3;
   localparam logic [7:0] BURST_CONTINUOUS = 8'h00;
   localparam logic [7:0] BURST_COUNT_RESET = 8'h00;

endpackage

// >>> core/mode_report_delay.sv
// module: heartbeat-paced pipeline that carries the live mode code into the status field
`timescale 1ns/100ps
module mode_report_delay
   import accel_status_pkg::*;
#(
   parameter int STAGES = MODE_REPORT_STAGES,
   parameter int WIDTH = 3
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic heartbeat_tick,
   input wire logic [WIDTH-1:0] live_code,
   output logic [WIDTH-1:0] reported_code
);

   logic [WIDTH-1:0] stage_reg [STAGES];

   // one stage per heartbeat edge, so the code lands within STAGES heartbeats
   genvar s;
   generate
      for (s = 0; s < STAGES; s++) begin : g_stage
         always_ff @(posedge clk) begin
            if (srst) begin
               stage_reg[s] <= WIDTH'(MODE_CODE_RESET);
            end else if (heartbeat_tick) begin
               stage_reg[s] <= (s == 0) ? live_code : stage_reg[(s == 0) ? 0 : s-1];
            end
         end
      end
   endgenerate

   assign reported_code = stage_reg[STAGES-1];

endmodule

// >>> bench/accel_status_properties.sv
// checker: timing relations between bus accesses, queue levels and flag outputs
`timescale 1ns/100ps
module accel_status_properties
   import accel_status_pkg::*;
#(
   parameter int DEPTH = QUEUE_DEPTH
) (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_RD,
   input wire logic REG_WR,
   input wire logic [7:0] REG_RDATA,
   input wire logic REG_RVALID,
   input wire logic IS_SPI,
   input wire logic WRITE_CLEAR_SEL,
   input wire logic REARM_ON_CLEAR,
   input wire logic [7:0] IRQ_ENABLE,
   input wire logic [4:0] QUEUE_WATERMARK_LEVEL,
   input wire logic [5:0] FIFO_COUNT,
   input wire logic DETECTOR_ENABLE,
   input wire logic DETECTOR_RESET,
   input wire logic [7:0] IRQ_FLAGS
);
   // ********
   // decode
   // ********
   // a clear needs the flags address and the access kind that the interface selects
   wire clear_hit = (REG_ADDR == INTERRUPT_FLAGS_ADDR) && ((IS_SPI | WRITE_CLEAR_SEL) ? REG_WR : REG_RD);
   wire is_full = FIFO_COUNT >= 6'(DEPTH);
   wire at_mark = FIFO_COUNT >= {1'b0, QUEUE_WATERMARK_LEVEL};

   // ********
   // sequences
   // ********
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   sequence status_read_s;
      REG_RD && REG_ADDR == OPERATING_STATUS_ADDR;
   endsequence
   sequence flags_read_s;
      REG_RD && REG_ADDR == INTERRUPT_FLAGS_ADDR;
   endsequence
   // the level must be left first, otherwise the arm may already be spent
   sequence full_arrives_s;
      !is_full ##1 (is_full && IRQ_ENABLE[QUEUE_FULL_IRQ_BIT]);
   endsequence
   sequence empty_arrives_s;
      FIFO_COUNT != 6'h00 ##1 (FIFO_COUNT == 6'h00 && IRQ_ENABLE[QUEUE_EMPTY_IRQ_BIT]);
   endsequence

   // ********
   // assertions
   // ********
   AST_STATUS_LEVELS: assert property (
      status_read_s |=> REG_RVALID && REG_RDATA[7:4] == {$past(IRQ_FLAGS) != 8'h00, $past(at_mark),
      $past(is_full), $past(FIFO_COUNT) == 6'h00}) else $error("status read gave wrong levels");
   AST_ENABLE_GATE: assert property (
      1'b1 |=> (IRQ_FLAGS & ~$past(IRQ_FLAGS) & ~$past(IRQ_ENABLE)) == 8'h00)
      else $error("flag set while its enable was low");
   AST_FLAGS_READ: assert property (
      flags_read_s |=> REG_RVALID && REG_RDATA == $past(IRQ_FLAGS)) else $error("flag read data wrong");
   AST_STICKY: assert property (
      !clear_hit |=> (IRQ_FLAGS & $past(IRQ_FLAGS)) == $past(IRQ_FLAGS)) else $error("flag lost without clear");
   AST_CLEAR_ALL: assert property (
      clear_hit && IRQ_ENABLE == 8'h00 |=> IRQ_FLAGS == 8'h00) else $error("clear left a flag set");
   AST_FULL_SET: assert property (
      full_arrives_s |=> IRQ_FLAGS[QUEUE_FULL_IRQ_BIT]) else $error("full flag missed");
   AST_EMPTY_SET: assert property (
      empty_arrives_s |=> IRQ_FLAGS[QUEUE_EMPTY_IRQ_BIT]) else $error("empty flag missed");
   AST_WATERMARK_SET: assert property (
      IRQ_ENABLE[QUEUE_WATERMARK_IRQ_BIT] && at_mark |=> IRQ_FLAGS[QUEUE_WATERMARK_IRQ_BIT])
      else $error("watermark flag missed");
   AST_DETECTOR_RESET: assert property (
      DETECTOR_RESET == (REARM_ON_CLEAR && clear_hit && IRQ_FLAGS[COMBINED_ACTIVITY_IRQ_BIT]))
      else $error("detector reset pulse wrong");
   AST_HALT: assert property (
      $rose(IRQ_FLAGS[COMBINED_ACTIVITY_IRQ_BIT]) |-> !DETECTOR_ENABLE) else $error("detector not halted");
endmodule

bind accel_status_interrupt_flags accel_status_properties #(.DEPTH(DEPTH)) i_props (
   .CLK(CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_RDATA(REG_RDATA),
   .REG_RVALID(REG_RVALID), .IS_SPI(IS_SPI), .WRITE_CLEAR_SEL(WRITE_CLEAR_SEL), .REARM_ON_CLEAR(REARM_ON_CLEAR),
   .IRQ_ENABLE(IRQ_ENABLE), .QUEUE_WATERMARK_LEVEL(QUEUE_WATERMARK_LEVEL), .FIFO_COUNT(FIFO_COUNT),
   .DETECTOR_ENABLE(DETECTOR_ENABLE), .DETECTOR_RESET(DETECTOR_RESET), .IRQ_FLAGS(IRQ_FLAGS)
);

// >>> bench/status_host_model.sv
// host model: register bus master issuing one-cycle read and write strobes
`timescale 1ns/100ps
module status_host_model #(
   parameter int IDLE_GAP = 0
) (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   // ********
   // bus tasks
   // ********
   // idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
   end

   // data only counts when flagged valid, so a missing answer shows as unknown
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      repeat (IDLE_GAP) @(negedge clk);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a; // unqualified address is parked elsewhere
      d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
   endtask

   // writes carry no data; one to the flags address is the write clear
   task automatic wr(input logic [7:0] a);
      repeat (IDLE_GAP) @(negedge clk);
      @(negedge clk);
      reg_addr = a;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
   endtask
endmodule

// >>> bench/accel_status_interrupt_flags_tb_top.sv
// testbench: reads, clears, queue levels, mode reports and detector handling of the status block
`timescale 1ns/100ps
module accel_status_interrupt_flags_tb_top
   import accel_status_pkg::*;
();
   // ********
   // signals
   // ********
   logic clk, srst, reg_rd, reg_wr, reg_rvalid, is_spi, write_clear_sel, rearm_on_clear;
   logic mode_cmd_wr, heartbeat_tick, sample_tick, sample_written, sample_read, activity_event;
   logic sampling_enable, detector_enable, queue_enable, detector_reset, any_irq_pending;
   logic [7:0] reg_addr, reg_rdata, irq_enable, burst_count, irq_flags;
   logic [5:0] fifo_count;
   logic [4:0] watermark;
   logic [2:0] mode_cmd, prev;
   int err_count, n_checks;
   logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7, 3'h0};
   // queue count then expected flags after it settles
   logic [13:0] steps [8] = '{14'h2060, 14'h2040, 14'h0440, 14'h0400, 14'h2060, 14'h0050, 14'h0000, 14'h0540};

   accel_status_interrupt_flags #(.DEPTH(QUEUE_DEPTH)) i_dut (
      .CLK(clk), .SRST(srst), .REG_ADDR(reg_addr), .REG_RD(reg_rd), .REG_WR(reg_wr), .REG_RDATA(reg_rdata),
      .REG_RVALID(reg_rvalid), .IS_SPI(is_spi), .WRITE_CLEAR_SEL(write_clear_sel), .REARM_ON_CLEAR(rearm_on_clear),
      .IRQ_ENABLE(irq_enable), .QUEUE_WATERMARK_LEVEL(watermark), .FIFO_COUNT(fifo_count), .MODE_CMD(mode_cmd),
      .MODE_CMD_WR(mode_cmd_wr), .BURST_SAMPLE_COUNT(burst_count), .HEARTBEAT_TICK(heartbeat_tick),
      .SAMPLE_TICK(sample_tick), .SAMPLE_WRITTEN(sample_written), .SAMPLE_READ(sample_read),
      .ACTIVITY_EVENT(activity_event), .SAMPLING_ENABLE(sampling_enable), .DETECTOR_ENABLE(detector_enable),
      .QUEUE_ENABLE(queue_enable), .DETECTOR_RESET(detector_reset), .ANY_IRQ_PENDING(any_irq_pending),
      .IRQ_FLAGS(irq_flags));
   status_host_model #(.IDLE_GAP(1)) i_host (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   // ********
   // tasks
   // ********
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] d;
      i_host.rd(a, d);
      chk8(d & m, e);
   endtask
   task automatic rd_flags(input logic [7:0] e);
      rd_chk(INTERRUPT_FLAGS_ADDR, 8'hFF, e);
   endtask
   // strobes last one cycle; the next pulse always starts a cycle later
   task automatic pulse(ref logic s);
      @(negedge clk) s = 1'b1;
      @(negedge clk) s = 1'b0;
   endtask
   task automatic mode_wr(input logic [2:0] c);
      mode_cmd = c;
      pulse(mode_cmd_wr);
   endtask
   task automatic set_count(input logic [5:0] c);
      @(negedge clk) fifo_count = c;
      @(negedge clk);
   endtask
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // ********
   // clock and watchdog
   // ********
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // the sequence needs well under two thousand cycles
   initial begin
      #100000;
      err_count++;
      report_and_stop();
   end

   // ********
   // main sequence
   // ********
   initial begin
      {srst, err_count, n_checks, watermark, fifo_count, mode_cmd, burst_count, irq_enable} = {1'b1, 64'h0, 5'h05, 25'h0};
      {is_spi, write_clear_sel, rearm_on_clear, mode_cmd_wr, heartbeat_tick} = 5'h00;
      {sample_tick, sample_written, sample_read, activity_event} = 4'h0;
      repeat (10) @(negedge clk);
      srst = 1'b0;
      rd_chk(OPERATING_STATUS_ADDR, 8'hFF, 8'h10);
      chk1(any_irq_pending, 1'b0);
      rd_flags(INTERRUPT_FLAGS_RESET);
      rd_chk(8'h0A, 8'hFF, 8'h00);
      irq_enable = 8'hFC;
      rd_flags(8'h10);
      rd_flags(8'h00);
      set_count(6'h20);
      rd_chk(OPERATING_STATUS_ADDR, 8'hFF, 8'hE0);
      chk1(any_irq_pending, 1'b1);
      foreach (steps[i]) begin
         set_count(steps[i][13:8]);
         rd_flags(steps[i][7:0]);
      end
      // write method on the optional setting, then on the serial interface
      for (int i = 0; i < 2; i++) begin
         is_spi = (i == 1);
         write_clear_sel = (i == 0);
         set_count(6'h05);
         set_count(6'h04);
         rd_flags(8'h40);
         i_host.wr(OPERATING_STATUS_ADDR);
         rd_flags(8'h40);
         i_host.wr(INTERRUPT_FLAGS_ADDR);
         rd_flags(8'h00);
      end
      {is_spi, write_clear_sel, irq_enable} = 10'h000;
      set_count(6'h20);
      rd_flags(8'h00);
      set_count(6'h04);
      irq_enable = 8'hFC;
      rd_flags(8'h00);
      prev = MODE_CODE_SLEEP;
      foreach (codes[i]) begin
         mode_wr(codes[i]);
         repeat (2) pulse(heartbeat_tick);
         rd_chk(OPERATING_STATUS_ADDR, 8'h07, {5'h00, prev});
         pulse(heartbeat_tick);
         rd_chk(OPERATING_STATUS_ADDR, 8'h07, {5'h00, codes[i]});
         chk1(sampling_enable, codes[i] inside {3'h5, 3'h6, 3'h7});
         chk1(queue_enable, codes[i] inside {3'h5, 3'h6, 3'h7});
         chk1(detector_enable, codes[i] inside {3'h2, 3'h6});
         prev = codes[i];
      end
      for (int r = 3; r < 5; r++) begin
         mode_wr(3'(r));
         repeat (3) pulse(heartbeat_tick);
         rd_chk(OPERATING_STATUS_ADDR, 8'h07, 8'h00);
      end
      burst_count = 8'h02;
      mode_wr(MODE_CODE_TRIGGERED_BURST);
      pulse(sample_tick);
      chk1(sampling_enable, 1'b1);
      rd_flags(8'h08);
      pulse(sample_tick);
      chk1(sampling_enable, 1'b0);
      rd_flags(8'h08);
      pulse(sample_tick);
      rd_flags(8'h00);
      mode_wr(MODE_CODE_ACTIVITY_WATCH);
      pulse(activity_event);
      chk1(sampling_enable, 1'b1);
      chk1(detector_enable, 1'b0);
      rd_flags(8'h04);
      pulse(activity_event);
      rd_flags(8'h00);
      mode_wr(MODE_CODE_COMBINED_WAKE);
      pulse(activity_event);
      chk1(detector_enable, 1'b0);
      rd_flags(8'h80);
      chk1(detector_enable, 1'b0);
      pulse(activity_event);
      rd_flags(8'h00);
      mode_wr(MODE_CODE_CONTINUOUS_WAKE);
      mode_wr(MODE_CODE_COMBINED_WAKE);
      chk1(detector_enable, 1'b1);
      rearm_on_clear = 1'b1;
      pulse(activity_event);
      rd_flags(8'h80);
      chk1(detector_enable, 1'b1);
      pulse(activity_event);
      rd_flags(8'h80);
      pulse(sample_written);
      rd_chk(OPERATING_STATUS_ADDR, 8'h08, 8'h08);
      rd_chk(OPERATING_STATUS_ADDR, 8'h08, 8'h08);
      pulse(sample_read);
      rd_chk(OPERATING_STATUS_ADDR, 8'h08, 8'h00);
      report_and_stop();
   end
endmodule
